//--- hdl/oscsc_irq.sv
// Sticky event status, enable and write-one-to-clear, one level interrupt
`timescale 1ns/1ps
module oscsc_irq (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [2:0] events,
    input  wire logic       clrWrite,
    input  wire logic       enWrite,
    input  wire logic [2:0] wdata,
    output logic      [2:0] status,
    output logic      [2:0] enable,
    output logic            irq
);
    import oscsc_pkg::*;

    genvar i;
    generate
        for (i = 0; i < IRQ_W; i++) begin : g_stat
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    status[i] <= 1'b0;
                end else if (events[i]) begin
                    status[i] <= 1'b1;
                end else if (clrWrite && wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enable <= IRQ_EN_RST;
        end else if (enWrite) begin
            enable <= wdata;
        end
    end

    assign irq = |(status & enable);

    a_set_beats_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        (events[IRQ_CLOCK_FAIL] && clrWrite && wdata[IRQ_CLOCK_FAIL])
        |=> status[IRQ_CLOCK_FAIL])
        else $error("event lost against a simultaneous clear");

endmodule

//--- hdl/oscsc_pkg.sv
// Constants, types and register layout of the oscillator source control block
package oscsc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SRC_W  = 3;
    localparam int IRQ_W  = 3;

    // Register word addresses
    localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h1;
    localparam logic [3:0] OFS_IRQ_CLR  = 4'h2;
    localparam logic [3:0] OFS_IRQ_EN   = 4'h3;

    // Field positions inside oscillator_control
    localparam int CUR_SRC_LSB     = 12;
    localparam int REQ_SRC_LSB     = 8;
    localparam int CLK_LOCK_BIT    = 7;
    localparam int REMAP_LOCK_BIT  = 6;
    localparam int PLL_LOCK_BIT    = 5;
    localparam int CLK_FAIL_BIT    = 3;
    localparam int SWITCH_EN_BIT   = 0;

    // Source codes, shared by current and requested fields
    localparam logic [2:0] SRC_FAST_INT      = 3'h0;
    localparam logic [2:0] SRC_FAST_INT_PLL  = 3'h1;
    localparam logic [2:0] SRC_PRIMARY       = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL   = 3'h3;
    localparam logic [2:0] SRC_RESERVED      = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_INT = 3'h5;
    localparam logic [2:0] SRC_FAST_INT_D16  = 3'h6;
    localparam logic [2:0] SRC_FAST_INT_DIV  = 3'h7;

    // Interrupt status bit positions
    localparam int IRQ_SWITCH_DONE = 0;
    localparam int IRQ_CLOCK_FAIL  = 1;
    localparam int IRQ_SWITCH_REJ  = 2;

    // Values after reset
    localparam logic [2:0]       SRC_RST    = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

    // Switch settle time
    localparam int CLK_PERIOD_NS  = 4;
    localparam int SWITCH_TIME_NS = 40;
    localparam int SWITCH_CYCLES  = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } oscsc_bus_s;

    typedef struct packed {
        logic             commit;
        logic             reject;
        logic [SRC_W-1:0] source;
    } oscsc_switch_s;

    typedef enum logic [1:0] {SW_IDLE, SW_CHECK, SW_WAIT, SW_DONE} oscsc_sw_state_e;

endpackage

//--- hdl/oscsc_switch_seq.sv
// Clock switch sequencer: checks a requested source and commits it after settling
`timescale 1ns/1ps
module oscsc_switch_seq (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   start,
    input  wire logic [2:0]             reqSource,
    input  wire logic [2:0]             curSource,
    output logic                        busy,
    output oscsc_pkg::oscsc_switch_s    result
);
    import oscsc_pkg::*;

    localparam logic [7:0] WAIT_LAST = 8'(SWITCH_CYCLES - 1);
    localparam int         SwMax     = SWITCH_CYCLES + 3;

    oscsc_sw_state_e state_r;
    logic [7:0]      waitCnt_r;
    logic [2:0]      target_r;
    logic            illegal;

    // Reserved code and direct moves between the two PLL modes are refused
    assign illegal = (target_r == SRC_RESERVED) ||
                     (curSource == SRC_PRIMARY_PLL && target_r == SRC_FAST_INT_PLL) ||
                     (curSource == SRC_FAST_INT_PLL && target_r == SRC_PRIMARY_PLL);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= SW_IDLE;
        end else begin
            case (state_r)
                SW_IDLE:  if (start) state_r <= SW_CHECK;
                SW_CHECK: state_r <= illegal ? SW_IDLE : SW_WAIT;
                SW_WAIT:  if (waitCnt_r == WAIT_LAST) state_r <= SW_DONE;
                default:  state_r <= SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            waitCnt_r <= 8'h00;
        end else if (state_r == SW_WAIT) begin
            waitCnt_r <= waitCnt_r + 8'h01;
        end else begin
            waitCnt_r <= 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            target_r <= SRC_RST;
        end else if (state_r == SW_IDLE && start) begin
            target_r <= reqSource;
        end
    end

    assign busy          = (state_r != SW_IDLE);
    assign result.commit = (state_r == SW_DONE); // RULE7
    assign result.reject = (state_r == SW_CHECK) && illegal; // RULE1
    assign result.source = target_r;

    sequence s_start_legal;
        start && !busy && reqSource != SRC_RESERVED &&
        !(curSource == SRC_PRIMARY_PLL && reqSource == SRC_FAST_INT_PLL) &&
        !(curSource == SRC_FAST_INT_PLL && reqSource == SRC_PRIMARY_PLL);
    endsequence

    sequence s_commit_seen;
        ##[1:SwMax] result.commit;
    endsequence

    a_switch_commits: assert property ( // RULE7
        @(posedge core_clk) disable iff (reset) s_start_legal |-> s_commit_seen)
        else $error("legal switch request did not commit in time");

    a_reserved_refused: assert property ( // RULE1
        @(posedge core_clk) disable iff (reset)
        (start && !busy && reqSource == SRC_RESERVED) |=> result.reject ##1 !busy)
        else $error("reserved source code was not refused");

endmodule

//--- hdl/oscsc_top.sv
// Oscillator source control register with clock switch, locks and fail flag
//
// Contract
// [RULE1] Current code 101 means low-power internal; 100 reserved
// [RULE2] Current code 011 primary with PLL, 010 direct
// [RULE3] Current code 001 fast internal, divider then PLL
// [RULE4] Clock lock clear: source and PLL changes accepted
// [RULE5] Bit 6 written one locks pin remapping
// [RULE6] Clock-fail cleared by software; written one traps
// [RULE7] Requested code adopted only when switch performed
`timescale 1ns/1ps
module oscsc_top (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic [3:0]          regAddr,
    input  wire logic [15:0]         regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [15:0]         regRdata,
    input  wire logic [2:0]          cfgInitSource,
    input  wire logic                pllLocked,
    input  wire logic                oscFailDetect,
    output logic      [2:0]          curSource,
    output logic                     clockLock,
    output logic                     pinRemapLock,
    output logic                     oscFailTrap,
    output logic                     switchBusy,
    output logic                     irq
);
    import oscsc_pkg::*;

    oscsc_bus_s    bus;
    oscsc_switch_s swResult;

    logic [2:0]  curSource_r;
    logic [2:0]  reqSource_r;
    logic        clockLock_r;
    logic        pinRemapLock_r;
    logic        clockFail_r;
    logic        swEnable_r;
    logic        initLoad_r;
    logic        oscFailTrap_r;
    logic [15:0] regRdata_r;
    logic [15:0] regRdata_nxt;

    logic        ctrlWr;
    logic        clrWr;
    logic        enWr;
    logic        swStart;
    logic        swFailSet;
    logic        usesPll;
    logic        pllLockBit;
    logic [15:0] ctrlWord;
    logic [2:0]  irqEvents;
    logic [2:0]  irqStatus;
    logic [2:0]  irqEnable;

    assign bus.wr    = regWr;
    assign bus.rd    = regRd;
    assign bus.addr  = regAddr;
    assign bus.wdata = regWdata;

    // Write decode
    always_comb begin
        ctrlWr = 1'b0;
        clrWr  = 1'b0;
        enWr   = 1'b0;
        if (bus.wr && bus.addr == OFS_OSC_CTRL) begin
            ctrlWr = 1'b1;
        end else if (bus.wr && bus.addr == OFS_IRQ_CLR) begin
            clrWr = 1'b1;
        end else if (bus.wr && bus.addr == OFS_IRQ_EN) begin
            enWr = 1'b1;
        end
    end

    // Straps are loaded on the first edge after reset release
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            initLoad_r <= 1'b1;
        end else begin
            initLoad_r <= 1'b0;
        end
    end

    // Clock lock sticks until reset once set
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clockLock_r <= 1'b0;
        end else if (ctrlWr && bus.wdata[CLK_LOCK_BIT]) begin
            clockLock_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pinRemapLock_r <= 1'b0;
        end else if (ctrlWr) begin
            pinRemapLock_r <= bus.wdata[REMAP_LOCK_BIT]; // RULE5
        end
    end

    // Requested source, writable only while unlocked and idle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reqSource_r <= SRC_RST;
        end else if (initLoad_r) begin
            reqSource_r <= cfgInitSource;
        end else if (ctrlWr && !clockLock_r && !switchBusy) begin
            reqSource_r <= bus.wdata[REQ_SRC_LSB +: SRC_W]; // RULE4
        end
    end

    assign swStart = ctrlWr && !clockLock_r && !switchBusy && !swEnable_r &&
                     bus.wdata[SWITCH_EN_BIT]; // RULE4

    // Switch enable: set by software, cleared when the switch ends
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            swEnable_r <= 1'b0;
        end else if (swStart) begin
            swEnable_r <= 1'b1;
        end else if (swResult.commit || swResult.reject) begin
            swEnable_r <= 1'b0;
        end
    end

    oscsc_switch_seq u_switch (
        .core_clk  (core_clk),
        .reset     (reset),
        .start     (swStart),
        .reqSource (bus.wdata[REQ_SRC_LSB +: SRC_W]),
        .curSource (curSource_r),
        .busy      (switchBusy),
        .result    (swResult)
    );

    // Current source takes the strap after reset (SRC_RST for the reserved code), then follows only a committed switch
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            curSource_r <= SRC_RST;
        end else if (initLoad_r) begin
            curSource_r <= (cfgInitSource == SRC_RESERVED) ? SRC_RST : cfgInitSource; // RULE1
        end else if (swResult.commit) begin
            curSource_r <= swResult.source; // RULE7
        end
    end

    // Clock fail: hardware or a software one sets, software zero clears
    assign swFailSet = ctrlWr && bus.wdata[CLK_FAIL_BIT];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clockFail_r <= 1'b0;
        end else if (oscFailDetect || swFailSet) begin
            clockFail_r <= 1'b1; // RULE6
        end else if (ctrlWr) begin
            clockFail_r <= 1'b0; // RULE6
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            oscFailTrap_r <= 1'b0;
        end else begin
            oscFailTrap_r <= oscFailDetect || swFailSet; // RULE6
        end
    end

    // PLL lock shown only while a PLL source is active
    assign usesPll    = (curSource_r == SRC_PRIMARY_PLL) ||
                        (curSource_r == SRC_FAST_INT_PLL); // RULE2 RULE3
    assign pllLockBit = usesPll && pllLocked;

    assign ctrlWord = {1'b0, curSource_r, 1'b0, reqSource_r, clockLock_r,
                       pinRemapLock_r, pllLockBit, 1'b0, clockFail_r, 2'b00,
                       swEnable_r};

    assign irqEvents[IRQ_SWITCH_DONE] = swResult.commit;
    assign irqEvents[IRQ_CLOCK_FAIL]  = oscFailDetect || swFailSet;
    assign irqEvents[IRQ_SWITCH_REJ]  = swResult.reject;

    oscsc_irq u_irq (
        .core_clk (core_clk),
        .reset    (reset),
        .events   (irqEvents),
        .clrWrite (clrWr),
        .enWrite  (enWr),
        .wdata    (bus.wdata[IRQ_W-1:0]),
        .status   (irqStatus),
        .enable   (irqEnable),
        .irq      (irq)
    );

    // Read decode; unmapped and clear addresses read zero
    always_comb begin
        regRdata_nxt = 16'h0000;
        if (bus.rd && bus.addr == OFS_OSC_CTRL) begin
            regRdata_nxt = ctrlWord;
        end else if (bus.rd && bus.addr == OFS_IRQ_STAT) begin
            regRdata_nxt = {13'h0000, irqStatus};
        end else if (bus.rd && bus.addr == OFS_IRQ_EN) begin
            regRdata_nxt = {13'h0000, irqEnable};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            regRdata_r <= 16'h0000;
        end else begin
            regRdata_r <= regRdata_nxt;
        end
    end

    assign regRdata     = regRdata_r;
    assign curSource    = curSource_r;
    assign clockLock    = clockLock_r;
    assign pinRemapLock = pinRemapLock_r;
    assign oscFailTrap  = oscFailTrap_r;

    sequence s_ctrl_write_fail;
        ctrlWr && bus.wdata[CLK_FAIL_BIT];
    endsequence

    sequence s_trap_and_flag;
        oscFailTrap && clockFail_r;
    endsequence

    a_cur_not_reserved: assert property ( // RULE1
        @(posedge core_clk) disable iff (reset) curSource_r != SRC_RESERVED)
        else $error("current source shows the reserved code");

    a_pll_cross_refused: assert property ( // RULE2
        @(posedge core_clk) disable iff (reset)
        (swStart && curSource_r == SRC_PRIMARY_PLL &&
         bus.wdata[REQ_SRC_LSB +: SRC_W] == SRC_FAST_INT_PLL)
        |=> ##1 curSource_r == SRC_PRIMARY_PLL && !swEnable_r)
        else $error("direct move from primary PLL was not refused");

    a_fast_internal_osc_div_pll_lock_bit: assert property ( // RULE3
        @(posedge core_clk) disable iff (reset)
        (curSource_r == SRC_FAST_INT_PLL && pllLocked) |-> ctrlWord[PLL_LOCK_BIT])
        else $error("PLL lock hidden while fast internal PLL is active");

    a_unlocked_accept: assert property ( // RULE4
        @(posedge core_clk) disable iff (reset || initLoad_r)
        (ctrlWr && !clockLock_r && !switchBusy)
        |=> reqSource_r == $past(bus.wdata[REQ_SRC_LSB +: SRC_W]))
        else $error("unlocked source write was not taken");

    a_locked_hold: assert property ( // RULE4
        @(posedge core_clk) disable iff (reset)
        (clockLock_r && !swResult.commit) |=> $stable(reqSource_r) && $stable(curSource_r))
        else $error("source changed while clock lock is set");

    a_remap_lock_set: assert property ( // RULE5
        @(posedge core_clk) disable iff (reset)
        ctrlWr |=> pinRemapLock == $past(bus.wdata[REMAP_LOCK_BIT]))
        else $error("pin remap lock does not follow bit 6");

    a_soft_fail_trap: assert property ( // RULE6
        @(posedge core_clk) disable iff (reset) s_ctrl_write_fail |=> s_trap_and_flag)
        else $error("software fail write did not raise the trap");

    a_fail_sticky: assert property ( // RULE6
        @(posedge core_clk) disable iff (reset)
        (clockFail_r && !ctrlWr) |=> clockFail_r)
        else $error("clock fail flag cleared without software");

    a_commit_adopts: assert property ( // RULE7
        @(posedge core_clk) disable iff (reset)
        swResult.commit |=> curSource_r == $past(swResult.source) && !swEnable_r)
        else $error("committed source not adopted");

    a_no_change_idle: assert property ( // RULE7
        @(posedge core_clk) disable iff (reset || initLoad_r)
        (!swResult.commit && !initLoad_r) |=> $stable(curSource_r))
        else $error("current source changed without a switch");

    a_read_latency: assert property (
        @(posedge core_clk) disable iff (reset)
        (bus.rd && bus.addr == OFS_OSC_CTRL) |=> regRdata == $past(ctrlWord))
        else $error("read data not returned one cycle after strobe");

    a_hw_fail_trap: assert property ( // RULE6
        @(posedge core_clk) disable iff (reset)
        oscFailDetect |=> oscFailTrap && clockFail_r)
        else $error("hardware fail did not raise the trap");

    a_trap_needs_event: assert property ( // RULE6
        @(posedge core_clk) disable iff (reset)
        !(oscFailDetect || swFailSet) |=> !oscFailTrap)
        else $error("fail trap raised without an event");

    a_primary_pll_bit: assert property ( // RULE2
        @(posedge core_clk) disable iff (reset)
        (curSource_r == SRC_PRIMARY_PLL) |-> ctrlWord[PLL_LOCK_BIT] == pllLocked)
        else $error("PLL lock bit wrong while primary PLL is active");

    a_pll_bit_hidden: assert property ( // RULE3
        @(posedge core_clk) disable iff (reset)
        !usesPll |-> !ctrlWord[PLL_LOCK_BIT])
        else $error("PLL lock bit shown while no PLL source is active");

    a_clock_lock_sticky: assert property ( // RULE4
        @(posedge core_clk) disable iff (reset)
        clockLock_r |=> clockLock_r)
        else $error("clock lock dropped without reset");

endmodule

//--- testbench/oscsc_top_test.sv
// Self-checking bench for the oscillator source control block
`timescale 1ns/1ps
module oscsc_top_test;
    import oscsc_pkg::*;

    logic        core_clk;
    logic        reset;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdata;
    logic [2:0]  cfgInitSource;
    logic        pllLocked;
    logic        oscFailDetect;
    logic [2:0]  curSource;
    logic        clockLock;
    logic        pinRemapLock;
    logic        oscFailTrap;
    logic        switchBusy;
    logic        irq;
    int          fails;
    int          testsRun;
    int          cycles;
    integer      seed;
    logic [2:0]  cur;
    logic [2:0]  reqF;
    logic        remap;
    logic        lockF;
    logic [15:0] rdv;

    oscsc_top u_oscsc_top (
        .core_clk      (core_clk),
        .reset         (reset),
        .regAddr       (regAddr),
        .regWdata      (regWdata),
        .regWr         (regWr),
        .regRd         (regRd),
        .regRdata      (regRdata),
        .cfgInitSource (cfgInitSource),
        .pllLocked     (pllLocked),
        .oscFailDetect (oscFailDetect),
        .curSource     (curSource),
        .clockLock     (clockLock),
        .pinRemapLock  (pinRemapLock),
        .oscFailTrap   (oscFailTrap),
        .switchBusy    (switchBusy),
        .irq           (irq)
    );

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    // Expected source after a switch request: reserved and direct PLL moves are refused
    function automatic logic [2:0] expSrc(input logic [2:0] c, input logic [2:0] r);
        if (r == SRC_RESERVED || (c == SRC_PRIMARY_PLL && r == SRC_FAST_INT_PLL) ||
            (c == SRC_FAST_INT_PLL && r == SRC_PRIMARY_PLL)) begin
            return c;
        end
        return r;
    endfunction

    function automatic logic [15:0] ctrlWord(input logic [2:0] r, input logic sw, input logic f);
        return (16'(r) << REQ_SRC_LSB) | (16'(lockF) << CLK_LOCK_BIT) |
               (16'(remap) << REMAP_LOCK_BIT) | (16'(f) << CLK_FAIL_BIT) |
               (16'(sw) << SWITCH_EN_BIT);
    endfunction

    function automatic logic [15:0] ctrlExp(input logic f);
        logic pll;
        pll = pllLocked && (cur == SRC_FAST_INT_PLL || cur == SRC_PRIMARY_PLL);
        return (16'(cur) << CUR_SRC_LSB) | (16'(reqF) << REQ_SRC_LSB) |
               (16'(lockF) << CLK_LOCK_BIT) | (16'(remap) << REMAP_LOCK_BIT) |
               (16'(pll) << PLL_LOCK_BIT) | (16'(f) << CLK_FAIL_BIT);
    endfunction

    task automatic conclude();
        if (fails == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
        @(posedge core_clk);
    endtask

    // One switch request, checked before and at the commit edge, then status and clear
    task automatic doSwitch(input logic [2:0] r);
        logic [2:0] e;
        logic       rej;
        e   = lockF ? cur : expSrc(cur, r);
        rej = !lockF && (e != r);
        if (!lockF) begin
            reqF = r;
        end
        wr(OFS_OSC_CTRL, ctrlWord(r, 1'b1, 1'b0));
        repeat (11) begin
            pllLocked <= 1'($random(seed));
            @(posedge core_clk);
        end
        @(negedge core_clk);
        check(16'(curSource), 16'(cur));
        if (!rej && !lockF) begin
            check(16'(switchBusy), 16'h1);
        end
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'(curSource), 16'(e));
        check(16'(irq), 16'(!lockF));
        cur = e;
        @(posedge core_clk);
        rd(OFS_OSC_CTRL, rdv);
        check(rdv, ctrlExp(1'b0));
        rd(OFS_IRQ_STAT, rdv);
        check(rdv, lockF ? 16'h0 : (rej ? 16'h4 : 16'h1));
        wr(OFS_IRQ_CLR, 16'h0007);
        @(negedge core_clk);
        check(16'(irq), 16'h0);
        @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            conclude();
        end
    end

    initial begin
        reset = 1'b1;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        cfgInitSource = SRC_LOW_POWER_INT;
        pllLocked = 1'b0;
        oscFailDetect = 1'b0;
        fails = 0;
        testsRun = 0;
        cycles = 0;
        seed = 5735;
        remap = 1'b0;
        lockF = 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'({curSource, switchBusy, irq, oscFailTrap, clockLock}), 16'h0);
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        cur = SRC_LOW_POWER_INT;
        reqF = SRC_LOW_POWER_INT;
        wr(OFS_IRQ_EN, 16'h0007);
        rd(OFS_OSC_CTRL, rdv);
        check(rdv, ctrlExp(1'b0));
        doSwitch(SRC_RESERVED);
        doSwitch(SRC_PRIMARY);
        doSwitch(SRC_PRIMARY_PLL);
        doSwitch(SRC_FAST_INT_PLL);
        doSwitch(SRC_FAST_INT);
        doSwitch(SRC_FAST_INT_PLL);
        doSwitch(SRC_PRIMARY_PLL);
        doSwitch(SRC_FAST_INT_D16);
        doSwitch(SRC_LOW_POWER_INT);
        repeat (10) doSwitch(3'($random(seed)));
        // Software fail with its interrupt masked, then unmasked
        remap = 1'b1;
        wr(OFS_IRQ_EN, 16'h0005);
        @(posedge core_clk);
        wr(OFS_OSC_CTRL, ctrlWord(reqF, 1'b0, 1'b1));
        @(negedge core_clk);
        check(16'(pinRemapLock), 16'h1);
        check(16'({oscFailTrap, irq}), 16'h2);
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'(oscFailTrap), 16'h0);
        @(posedge core_clk);
        rd(OFS_OSC_CTRL, rdv);
        check(rdv, ctrlExp(1'b1));
        rd(OFS_IRQ_STAT, rdv);
        check(rdv, 16'h2);
        wr(OFS_IRQ_EN, 16'h0007);
        @(negedge core_clk);
        check(16'(irq), 16'h1);
        @(posedge core_clk);
        remap = 1'b0;
        wr(OFS_OSC_CTRL, ctrlWord(reqF, 1'b0, 1'b0));
        @(negedge core_clk);
        check(16'(pinRemapLock), 16'h0);
        @(posedge core_clk);
        rd(OFS_OSC_CTRL, rdv);
        check(rdv, ctrlExp(1'b0));
        // Hardware fail event
        oscFailDetect <= 1'b1;
        @(posedge core_clk);
        oscFailDetect <= 1'b0;
        @(negedge core_clk);
        check(16'(oscFailTrap), 16'h1);
        @(posedge core_clk);
        rd(OFS_OSC_CTRL, rdv);
        check(rdv, ctrlExp(1'b1));
        oscFailDetect <= 1'b1;
        wr(OFS_IRQ_CLR, 16'h0007);
        oscFailDetect <= 1'b0;
        rd(OFS_IRQ_STAT, rdv);
        check(rdv, 16'h2);
        wr(OFS_IRQ_CLR, 16'h0007);
        @(posedge core_clk);
        wr(OFS_OSC_CTRL, ctrlWord(reqF, 1'b0, 1'b0));
        rd(4'h9, rdv);
        check(rdv, 16'h0000);
        rd(OFS_IRQ_CLR, rdv);
        check(rdv, 16'h0000);
        // Clock lock freezes source selection
        lockF = 1'b1;
        wr(OFS_OSC_CTRL, ctrlWord(reqF, 1'b0, 1'b0));
        @(negedge core_clk);
        check(16'(clockLock), 16'h1);
        @(posedge core_clk);
        doSwitch(cur == SRC_PRIMARY ? SRC_FAST_INT : SRC_PRIMARY);
        // Second reset with the reserved strap code
        reset <= 1'b1;
        cfgInitSource <= SRC_RESERVED;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        check(16'({curSource, clockLock}), 16'h0);
        conclude();
    end
endmodule
